// file: rtl/sr_io_pkg.sv
`default_nettype none
package sr_io_pkg;

	// ----------------------------------------------------------------
	// Register map, byte addresses of 32-bit words
	// ----------------------------------------------------------------
	localparam logic [7:0] CTRL_OFS     = 8'h00; // Start requests.
	localparam logic [7:0] CONFIG_OFS   = 8'h04; // Strobe types per direction.
	localparam logic [7:0] OUT_LEN_OFS  = 8'h08; // Output bit length.
	localparam logic [7:0] IN_LEN_OFS   = 8'h0C; // Input bit length.
	localparam logic [7:0] STATUS_OFS   = 8'h10; // Busy and done flags.
	localparam logic [7:0] DIV_OFS      = 8'h14; // Half period of the shift clock.
	localparam logic [7:0] OUT_DATA_OFS = 8'h40; // Eight words of outgoing bits.
	localparam logic [7:0] IN_DATA_OFS  = 8'h60; // Eight words of received bits.

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTRL_WR_BIT    = 0; // Start an output transfer.
	localparam int CTRL_RD_BIT    = 1; // Start an input transfer.
	localparam int CFG_OUT_BIT    = 0; // Output strobe type.
	localparam int CFG_IN_BIT     = 1; // Input strobe type.
	localparam int ST_BUSY_BIT    = 0; // Transfer running or pending.
	localparam int ST_WR_DONE_BIT = 1; // Output transfer finished, sticky.
	localparam int ST_RD_DONE_BIT = 2; // Input transfer finished, sticky.

	// ----------------------------------------------------------------
	// Sizes, reset values and timing
	// ----------------------------------------------------------------
	localparam int          MAX_BITS      = 256;    // Longest chain per direction.
	localparam int          LEN_W         = 9;      // Holds 1 to 256.
	localparam logic [8:0]  LEN_RESET     = 9'h008; // Length after reset.
	localparam int          CLK_HZ        = 40000000;
	localparam int          SCLK_MIN_HZ   = 150000; // Slowest allowed shift clock.
	// Longest half period, rounded down so the clock never runs slower.
	localparam int          HALF_MAX      = CLK_HZ / (2 * SCLK_MIN_HZ);
	localparam logic [7:0]  DIV_RESET     = 8'(HALF_MAX);

	// Strobe polarity choices; the shift clock rises in both.
	typedef enum logic {
		rising_clock_rising_strobe,
		rising_clock_low_strobe
	} sr_type_t;

endpackage
`default_nettype wire

// file: rtl/sr_tick_if.sv
`timescale 1ns/10ps
`default_nettype none
// Carries the half-period request and its tick between controller and divider.
interface sr_tick_if;
	logic       run;  // Divider counts while high.
	logic [7:0] half; // Clock cycles per half period.
	logic       tick; // One-cycle enable at each half period.

	modport ctl (output run, output half, input tick);
	modport div (input run, input half, output tick);
endinterface
`default_nettype wire

// file: rtl/sr_half_div.sv
`timescale 1ns/10ps
`default_nettype none
// Makes one enable pulse per shift-clock half period.
module sr_half_div (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	// Tick carrier
	sr_tick_if.div    tk
);

	logic [7:0] cnt_reg; // Cycles seen in this half period.

	// ----------------------------------------------------------------
	// Counter, restarted whenever the controller stops it
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_reg <= 8'h00;
			tk.tick <= 1'b0;
		end else if (!tk.run) begin
			// Preset to one, because the controller only sees the registered tick a cycle
			// late. Starting from zero would stretch the first half period by one cycle and
			// push the slowest shift clock below its floor.
			cnt_reg <= 8'h01;
			tk.tick <= 1'b0;
		end else if (cnt_reg >= tk.half - 8'h01) begin
			cnt_reg <= 8'h00;
			tk.tick <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + 8'h01;
			tk.tick <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// file: rtl/sr_sync2.sv
`timescale 1ns/10ps
`default_nettype none
// Two-stage synchroniser for a pin level.
module sr_sync2 (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	// Level in and out
	input  wire logic d_i,
	output logic      q_o
);

	logic meta_reg; // First stage, read by the second stage only.

	// ----------------------------------------------------------------
	// Sampling chain
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_reg <= 1'b1;
			q_o      <= 1'b1;
		end else begin
			meta_reg <= d_i;
			q_o      <= meta_reg;
		end
	end

endmodule
`default_nettype wire

// file: rtl/shift_register_io_port.sv
// How it works
// R01: Latch strobe edge moves bits to outputs.
// R02: Serial output sends most significant bit first.
// R03: Received bits assembled most significant first.
// R04: Load strobe captures parallel inputs before shifting.
// R05: One shift clock times both directions.
// R06: Up to 256 bits each way, independently.
// R07: Shift clock never slower than 150 kHz.
// R08: Rising-strobe and low-level-strobe types selectable.
// R09: Type and length per direction, changeable between transfers.
// R10: Exactly configured clock pulses, then one latch.
`timescale 1ns/10ps
`default_nettype none
module shift_register_io_port (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	// Register port
	input  wire logic [7:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [31:0] rdata_o,
	// Shift-register chain pins
	output logic             sclk_o,
	output logic             sdo_o,
	input  wire logic        sdi_i,
	output logic             latch_o,
	output logic             load_o,
	// Status
	output logic             busy_o
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_LOAD,
		ST_LOW,
		ST_HIGH,
		ST_LATCH
	} state_t;

	state_t                     state_reg;     // Transfer sequencer.
	sr_io_pkg::sr_type_t        out_type_reg;  // Output strobe type.
	sr_io_pkg::sr_type_t        in_type_reg;   // Input strobe type.
	logic [sr_io_pkg::LEN_W-1:0] out_len_reg;  // Output bit length.
	logic [sr_io_pkg::LEN_W-1:0] in_len_reg;   // Input bit length.
	logic [7:0]                 div_reg;       // Half period in clock cycles.
	logic                       pend_wr_reg;   // Output transfer requested.
	logic                       pend_rd_reg;   // Input transfer requested.
	logic                       mode_rd_reg;   // Running transfer is an input one.
	logic                       wr_done_reg;   // Sticky output-done flag.
	logic                       rd_done_reg;   // Sticky input-done flag.
	logic [7:0]                 idx_reg;       // Bit position now on the line.
	logic [31:0]                out_mem [0:7]; // Outgoing chain image.
	logic [31:0]                in_mem  [0:7]; // Incoming chain image.
	logic                       sdi_sync;      // Data-in after two flip-flops.
	logic                       busy;          // Any work running or pending.
	logic                       fin_pulse;     // Sequencer finished a transfer.
	logic                       wr_hit;        // Any write accepted while not busy.
	logic [31:0]                rd_word;       // Read mux result.
	logic [sr_io_pkg::LEN_W-1:0] wlen;         // Write data as a length.
	logic                       out_idle;      // Resting level of the latch pin.
	logic                       in_idle;       // Resting level of the load pin.

	sr_tick_if tk ();

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// A low-level strobe rests high; a rising strobe rests low.
	assign out_idle  = (out_type_reg == sr_io_pkg::rising_clock_low_strobe); // [R08]
	assign in_idle   = (in_type_reg == sr_io_pkg::rising_clock_low_strobe); // [R08]
	assign busy      = (state_reg != ST_IDLE) || pend_wr_reg || pend_rd_reg;
	assign wlen      = wdata_i[sr_io_pkg::LEN_W-1:0];
	assign wr_hit    = wr_i && !busy;
	assign fin_pulse = tk.tick && (((state_reg == ST_HIGH) && (idx_reg == 8'h00) && mode_rd_reg)
		|| (state_reg == ST_LATCH));

	// The divider only runs while a transfer is on the wires.
	assign tk.run  = (state_reg != ST_IDLE);
	assign tk.half = div_reg;

	sr_half_div u_div (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.tk      (tk)
	);

	// Data-in is a pin, so it is synchronised before anything samples it.
	sr_sync2 u_sync (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.d_i     (sdi_i),
		.q_o     (sdi_sync)
	);

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	// Writes are ignored while busy so a running chain never sees its
	// length or polarity change under it.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			out_type_reg <= sr_io_pkg::rising_clock_rising_strobe;
			in_type_reg  <= sr_io_pkg::rising_clock_rising_strobe;
			out_len_reg  <= sr_io_pkg::LEN_RESET;
			in_len_reg   <= sr_io_pkg::LEN_RESET;
			div_reg      <= sr_io_pkg::DIV_RESET;
		end else if (wr_hit) begin
			if (addr_i == sr_io_pkg::CONFIG_OFS) begin
				out_type_reg <= sr_io_pkg::sr_type_t'(wdata_i[sr_io_pkg::CFG_OUT_BIT]); // [R09]
				in_type_reg  <= sr_io_pkg::sr_type_t'(wdata_i[sr_io_pkg::CFG_IN_BIT]); // [R09]
			end else if (addr_i == sr_io_pkg::OUT_LEN_OFS) begin
				// Lengths outside 1..256 are refused and the old value stays.
				if (wlen != 9'h000 && wlen <= 9'(sr_io_pkg::MAX_BITS)) begin
					out_len_reg <= wlen; // [R06] [R09]
				end
			end else if (addr_i == sr_io_pkg::IN_LEN_OFS) begin
				if (wlen != 9'h000 && wlen <= 9'(sr_io_pkg::MAX_BITS)) begin
					in_len_reg <= wlen; // [R06] [R09]
				end
			end else if (addr_i == sr_io_pkg::DIV_OFS) begin
				// Clamped so the shift clock cannot fall below its floor.
				if (wdata_i[7:0] == 8'h00) begin
					div_reg <= 8'h01;
				end else if (wdata_i[7:0] > sr_io_pkg::DIV_RESET) begin
					div_reg <= sr_io_pkg::DIV_RESET; // [R07]
				end else begin
					div_reg <= wdata_i[7:0];
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Outgoing data image
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < 8; i++) begin
				out_mem[i] <= 32'h00000000;
			end
		end else if (wr_hit && addr_i[7:5] == sr_io_pkg::OUT_DATA_OFS[7:5]) begin
			out_mem[addr_i[4:2]] <= wdata_i;
		end
	end

	// ----------------------------------------------------------------
	// Start requests and sticky done flags
	// ----------------------------------------------------------------
	// A done flag is cleared by writing one; a finish in the same cycle wins.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pend_wr_reg <= 1'b0;
			pend_rd_reg <= 1'b0;
			wr_done_reg <= 1'b0;
			rd_done_reg <= 1'b0;
		end else begin
			if (wr_hit && addr_i == sr_io_pkg::CTRL_OFS) begin
				pend_wr_reg <= wdata_i[sr_io_pkg::CTRL_WR_BIT];
				pend_rd_reg <= wdata_i[sr_io_pkg::CTRL_RD_BIT];
			end else if (state_reg == ST_IDLE && pend_wr_reg) begin
				pend_wr_reg <= 1'b0;
			end else if (state_reg == ST_IDLE && pend_rd_reg) begin
				pend_rd_reg <= 1'b0;
			end
			if (fin_pulse && !mode_rd_reg) begin
				wr_done_reg <= 1'b1;
			end else if (wr_i && addr_i == sr_io_pkg::STATUS_OFS && wdata_i[sr_io_pkg::ST_WR_DONE_BIT]) begin
				wr_done_reg <= 1'b0;
			end
			if (fin_pulse && mode_rd_reg) begin
				rd_done_reg <= 1'b1;
			end else if (wr_i && addr_i == sr_io_pkg::STATUS_OFS && wdata_i[sr_io_pkg::ST_RD_DONE_BIT]) begin
				rd_done_reg <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Transfer sequencer
	// ----------------------------------------------------------------
	// Each state after ST_IDLE lasts one half period. Data changes while the clock is low
	// and the far end shifts on the rising edge. An output transfer runs
	// before an input one when both are asked for at once.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_reg   <= ST_IDLE;
			mode_rd_reg <= 1'b0;
			idx_reg     <= 8'h00;
			sclk_o      <= 1'b0;
			sdo_o       <= 1'b0;
			latch_o     <= 1'b0;
			load_o      <= 1'b0;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					sclk_o  <= 1'b0;
					latch_o <= out_idle;
					load_o  <= in_idle;
					if (pend_wr_reg) begin
						mode_rd_reg <= 1'b0;
						idx_reg     <= 8'(out_len_reg - 9'h001);
						// First bit out is the top one of the chain.
						sdo_o       <= out_mem[out_len_reg[7:5] - 3'(out_len_reg[4:0] == 5'h00)]
							[5'(out_len_reg[4:0] - 5'h01)]; // [R02]
						state_reg   <= ST_LOW;
					end else if (pend_rd_reg) begin
						mode_rd_reg <= 1'b1;
						idx_reg     <= 8'(in_len_reg - 9'h001);
						sdo_o       <= 1'b0;
						load_o      <= !in_idle; // [R04]
						state_reg   <= ST_LOAD;
					end
				end
				ST_LOAD: begin
					if (tk.tick) begin
						// Parallel inputs are captured; release before clocking.
						load_o    <= in_idle; // [R04]
						state_reg <= ST_LOW;
					end
				end
				ST_LOW: begin
					if (tk.tick) begin
						sclk_o    <= 1'b1; // [R05]
						state_reg <= ST_HIGH;
					end
				end
				ST_HIGH: begin
					if (tk.tick) begin
						sclk_o <= 1'b0; // [R05]
						if (idx_reg == 8'h00) begin
							if (mode_rd_reg) begin
								state_reg <= ST_IDLE;
							end else begin
								latch_o   <= !out_idle; // [R01] [R10]
								state_reg <= ST_LATCH;
							end
						end else begin
							idx_reg <= idx_reg - 8'h01; // [R10]
							if (!mode_rd_reg) begin
								sdo_o <= out_mem[3'((idx_reg - 8'h01) >> 5)][5'(idx_reg - 8'h01)]; // [R02]
							end
							state_reg <= ST_LOW;
						end
					end
				end
				ST_LATCH: begin
					if (tk.tick) begin
						// Return to rest; for a rising strobe the active edge
						// was the one that entered this state.
						latch_o   <= out_idle; // [R01]
						state_reg <= ST_IDLE;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Incoming data image
	// ----------------------------------------------------------------
	// Cleared at the start of an input transfer so bits above the length
	// read as zero. Data-in is sampled just before the rising shift edge.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < 8; i++) begin
				in_mem[i] <= 32'h00000000;
			end
		end else if (state_reg == ST_IDLE && !pend_wr_reg && pend_rd_reg) begin
			for (int i = 0; i < 8; i++) begin
				in_mem[i] <= 32'h00000000;
			end
		end else if (state_reg == ST_LOW && tk.tick && mode_rd_reg) begin
			in_mem[idx_reg[7:5]][idx_reg[4:0]] <= sdi_sync; // [R03] [R05]
		end
	end

	// ----------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------
	always_comb begin
		rd_word = 32'h00000000;
		if (addr_i == sr_io_pkg::CONFIG_OFS) begin
			rd_word[sr_io_pkg::CFG_OUT_BIT] = out_type_reg;
			rd_word[sr_io_pkg::CFG_IN_BIT]  = in_type_reg;
		end else if (addr_i == sr_io_pkg::OUT_LEN_OFS) begin
			rd_word[sr_io_pkg::LEN_W-1:0] = out_len_reg;
		end else if (addr_i == sr_io_pkg::IN_LEN_OFS) begin
			rd_word[sr_io_pkg::LEN_W-1:0] = in_len_reg;
		end else if (addr_i == sr_io_pkg::STATUS_OFS) begin
			rd_word[sr_io_pkg::ST_BUSY_BIT]    = busy;
			rd_word[sr_io_pkg::ST_WR_DONE_BIT] = wr_done_reg;
			rd_word[sr_io_pkg::ST_RD_DONE_BIT] = rd_done_reg;
		end else if (addr_i == sr_io_pkg::DIV_OFS) begin
			rd_word[7:0] = div_reg;
		end else if (addr_i[7:5] == sr_io_pkg::OUT_DATA_OFS[7:5]) begin
			rd_word = out_mem[addr_i[4:2]];
		end else if (addr_i[7:5] == sr_io_pkg::IN_DATA_OFS[7:5]) begin
			rd_word = in_mem[addr_i[4:2]];
		end
	end

	// Read data stand for exactly the cycle after the strobe.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_o <= 32'h00000000;
			busy_o  <= 1'b0;
		end else begin
			rdata_o <= rd_i ? rd_word : 32'h00000000;
			busy_o  <= busy;
		end
	end

endmodule
`default_nettype wire

// file: testbench/sr_chain_model.sv
`timescale 1ns/10ps
`default_nettype none
// Far-side chains: one output shift/storage register and one input load/shift register.
module sr_chain_model (
	// Chain pins
	input  wire logic         sclk_i,
	input  wire logic         sdo_i,
	input  wire logic         latch_i,
	input  wire logic         load_i,
	output logic              sdi_o,
	// Parallel sides and strobe type
	input  wire logic         low_i,
	input  wire logic [255:0] par_i,
	output logic      [255:0] par_o
);
	logic [255:0] out_sh = '0; // Output shift stage.
	logic [255:0] in_sh  = '0; // Input shift stage; fills with ones as the pin is pulled up.
	// Both chains move on the rising shift clock only.
	always @(posedge sclk_i) begin
		out_sh <= {out_sh[254:0], sdo_i};
		in_sh  <= {in_sh[254:0], 1'b1};
	end
	// The storage stage copies the shift stage on a rising strobe.
	always @(posedge latch_i) par_o <= out_sh;
	// Parallel capture: on the rising edge, or as the low level begins.
	always @(posedge load_i) if (!low_i) in_sh <= par_i;
	always @(negedge load_i) if (low_i) in_sh <= par_i;
	assign sdi_o = in_sh[255];
endmodule
`default_nettype wire

// file: testbench/sr_io_port_chk.sv
`timescale 1ns/10ps
`default_nettype none
// Watches the register port and the chain pins of the serial I/O port.
module sr_io_port_chk (
	input wire logic        clk_i,
	input wire logic        rst_n_i,
	input wire logic [7:0]  addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic        wr_i,
	input wire logic        rd_i,
	input wire logic [31:0] rdata_o,
	input wire logic        sclk_o,
	input wire logic        sdo_o,
	input wire logic        sdi_i,
	input wire logic        latch_o,
	input wire logic        load_o,
	input wire logic        busy_o
);
	logic [1:0] cfg_q;  // Strobe types as written while idle.
	logic [1:0] cfg_d;  // Same, one cycle later, as the pins follow a register.
	logic [7:0] hi_cnt; // Cycles the shift clock has stood high.
	logic       steady; // Types unchanged for a cycle.
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);
	// The port ignores configuration while busy, so only idle writes count.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cfg_q <= 2'h0;
			cfg_d <= 2'h0;
		end else begin
			if (wr_i && !busy_o && addr_i == sr_io_pkg::CONFIG_OFS) cfg_q <= wdata_i[1:0];
			cfg_d <= cfg_q;
		end
	end
	// Length of the present high phase.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) hi_cnt <= 8'h00;
		else hi_cnt <= sclk_o ? hi_cnt + 8'h01 : 8'h00;
	end
	assign steady = (cfg_q == cfg_d);
	AST_SDO_HOLD: assert property (sclk_o && $past(sclk_o) |-> $stable(sdo_o))
		else $error("data out moved while shift clock high");
	AST_SCLK_HIGH_MAX: assert property (hi_cnt <= 8'(sr_io_pkg::HALF_MAX))
		else $error("shift clock high phase too long");
	AST_SCLK_IDLE: assert property (!busy_o |-> !sclk_o)
		else $error("shift clock pulsed while idle");
	AST_LATCH_QUIET: assert property (steady && latch_o != cfg_d[0] |-> !sclk_o && busy_o)
		else $error("latch active during shifting or idle");
	AST_LOAD_QUIET: assert property (steady && load_o != cfg_d[1] |-> !sclk_o && busy_o)
		else $error("load active during shifting or idle");
	AST_STROBE_REST: assert property (!busy_o && $past(!busy_o) && steady
		|-> latch_o == cfg_d[0] && load_o == cfg_d[1])
		else $error("strobe rest level does not match type");
	AST_START: assert property (wr_i && !busy_o && addr_i == sr_io_pkg::CTRL_OFS && wdata_i[1:0] != 2'h0
		|-> ##[1:2] busy_o)
		else $error("start request did not make the port busy");
	AST_RDATA_ZERO: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
		else $error("read data outside the read cycle");
	cover property ($rose(sclk_o));
	cover property (steady && latch_o != cfg_d[0]);
	cover property (steady && load_o != cfg_d[1]);
endmodule
bind shift_register_io_port sr_io_port_chk u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
	.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sclk_o(sclk_o), .sdo_o(sdo_o),
	.sdi_i(sdi_i), .latch_o(latch_o), .load_o(load_o), .busy_o(busy_o));
`default_nettype wire

// file: testbench/tb_shift_register_io_port.sv
`timescale 1ns/10ps
`default_nettype none
module tb_shift_register_io_port;
	logic clk_i, rst_n_i, wr_i, rd_i, sclk_o, sdo_o, sdi_i, latch_o, load_o, busy_o, in_low;
	logic [7:0]   addr_i;
	logic [31:0]  wdata_i, rdata_o;
	logic [255:0] par_in, par_out;
	int miscompares, total_checks, cyc, n_sck, n_lat, n_ld;
	shift_register_io_port DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sclk_o(sclk_o), .sdo_o(sdo_o), .sdi_i(sdi_i),
		.latch_o(latch_o), .load_o(load_o), .busy_o(busy_o));
	sr_chain_model u_chain (.sclk_i(sclk_o), .sdo_i(sdo_o), .latch_i(latch_o), .load_i(load_o),
		.sdi_o(sdi_i), .low_i(in_low), .par_i(par_in), .par_o(par_out));
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	// Pulse and strobe counters; a strobe pulse is two toggles whatever its type.
	always @(posedge sclk_o) n_sck++;
	always @(latch_o) n_lat++;
	always @(load_o) n_ld++;
	// Cut a hang short well beyond the longest expected run.
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 40000) begin
			miscompares++;
			stop_test();
		end
	end
	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [255:0] exp, input logic [255:0] got);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Bus cycles; a free cycle follows each write so a strobe is never set twice at one step.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
		@(posedge clk_i);
	endtask
	task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] v;
		rd(a, v);
		chk(what, {224'h0, exp}, {224'h0, v});
	endtask
	// Starts a transfer, optionally tries a length write while busy, waits for idle.
	task automatic run(input logic [1:0] ctrl, input logic poke);
		int n;
		n_sck = 0;
		n_lat = 0;
		n_ld = 0;
		wr(sr_io_pkg::CTRL_OFS, {30'h0, ctrl});
		repeat (3) @(posedge clk_i);
		if (poke) wr(sr_io_pkg::OUT_LEN_OFS, 32'h5);
		n = 0;
		while (busy_o !== 1'b0 && n < 9000) begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 9000) begin
			miscompares++;
			$display("BAD busy end expected 0 seen %b", busy_o);
		end
	endtask
	task automatic t_regs();
		chk("idle pins", 256'h0, {253'h0, sclk_o, latch_o, load_o});
		rchk("out len", sr_io_pkg::OUT_LEN_OFS, {23'h0, sr_io_pkg::LEN_RESET});
		rchk("div", sr_io_pkg::DIV_OFS, {24'h0, sr_io_pkg::DIV_RESET});
		rchk("unmapped", 8'h30, 32'h0);
		wr(sr_io_pkg::DIV_OFS, 32'hFF);
		rchk("div clamp", sr_io_pkg::DIV_OFS, {24'h0, sr_io_pkg::DIV_RESET});
		wr(sr_io_pkg::IN_LEN_OFS, 32'h101);
		rchk("len over", sr_io_pkg::IN_LEN_OFS, {23'h0, sr_io_pkg::LEN_RESET});
		wr(sr_io_pkg::DIV_OFS, 32'h4);
		$display("test regs done");
	endtask
	task automatic t_out(input int len, input logic low, input logic [255:0] data);
		logic [255:0] m;
		m = {256{1'b1}} >> (256 - len);
		in_low <= low;
		wr(sr_io_pkg::CONFIG_OFS, {30'h0, low, low});
		wr(sr_io_pkg::OUT_LEN_OFS, 32'(len));
		for (int i = 0; i < 8; i++) wr(sr_io_pkg::OUT_DATA_OFS + 8'(4 * i), data[32*i +: 32]);
		run(2'h1, 1'b0);
		chk("out pulses", 256'(len), 256'(n_sck));
		chk("latch toggles", 256'h2, 256'(n_lat));
		chk("outputs", data & m, par_out & m);
		rchk("status", sr_io_pkg::STATUS_OFS, 32'h2);
		wr(sr_io_pkg::STATUS_OFS, 32'h6);
		$display("test out %0d done", len);
	endtask
	task automatic t_in(input int len, input logic low, input logic [255:0] par);
		logic [255:0] v;
		logic [31:0]  w;
		in_low <= low;
		par_in <= par;
		wr(sr_io_pkg::CONFIG_OFS, {30'h0, low, low});
		wr(sr_io_pkg::IN_LEN_OFS, 32'(len));
		run(2'h2, 1'b0);
		chk("in pulses", 256'(len), 256'(n_sck));
		chk("load toggles", 256'h2, 256'(n_ld));
		for (int i = 0; i < 8; i++) begin
			rd(sr_io_pkg::IN_DATA_OFS + 8'(4 * i), w);
			v[32*i +: 32] = w;
		end
		chk("inputs", par >> (256 - len), v);
		wr(sr_io_pkg::STATUS_OFS, 32'h6);
		$display("test in %0d done", len);
	endtask
	task automatic t_both();
		wr(sr_io_pkg::OUT_LEN_OFS, 32'h10);
		wr(sr_io_pkg::IN_LEN_OFS, 32'h18);
		run(2'h3, 1'b1);
		chk("both pulses", 256'h28, 256'(n_sck));
		rchk("both status", sr_io_pkg::STATUS_OFS, 32'h6);
		rchk("busy write", sr_io_pkg::OUT_LEN_OFS, 32'h10);
		$display("test both done");
	endtask
	initial begin
		{rst_n_i, wr_i, rd_i, in_low, addr_i, wdata_i, par_in} = '0;
		repeat (3) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		t_regs();
		t_out(32, 1'b0, {8{32'h96C3_A50F}});
		t_out(256, 1'b1, {4{64'h0F1E_2D3C_4B5A_6978}});
		t_out(1, 1'b0, 256'h1);
		t_in(32, 1'b0, {8{32'hD21E_4B87}});
		t_in(256, 1'b1, {4{64'hF0E1_D2C3_B4A5_9687}});
		t_both();
		stop_test();
	end
endmodule
`default_nettype wire
